// ===== design/tlic_ctrl.sv
module tlic_ctrl
	import tlic_pkg::*;
(
	// clock and reset
	input  wire logic        mclk,
	input  wire logic        rst,
	// special function register port from the core
	input  wire logic [7:0]  sfr_addr,
	input  wire logic [7:0]  sfr_wdata,
	input  wire logic        sfr_wr,
	input  wire logic        sfr_bit_wr,
	input  wire logic [2:0]  sfr_bit_sel,
	input  wire logic        sfr_bit_val,
	output logic      [7:0]  sfr_rdata,
	// request lines, levels held until the service routine clears the cause
	input  wire logic        ext0_request_flag,
	input  wire logic        timer0_overflow_flag,
	input  wire logic        ext1_request_flag,
	input  wire logic        timer1_overflow_flag,
	input  wire logic        uart_rx_done,
	input  wire logic        uart_tx_done,
	input  wire logic        timer2_overflow_flag,
	input  wire logic        timer2_external_flag,
	input  wire logic        main_converter_ready,
	input  wire logic        aux_converter_ready,
	input  wire logic        spi_done_flag,
	input  wire logic        two_wire_done_flag,
	input  wire logic        supply_monitor_flag,
	input  wire logic        interval_counter_flag,
	input  wire logic        watchdog_timeout_flag,
	input  wire logic        watchdog_irq_select,
	input  wire logic [3:0]  watchdog_period,
	// core handshake
	input  wire logic        core_irq_ready,
	input  wire logic        core_reti,
	output logic             irq_push_pc,
	output logic             irq_load_pc,
	output logic      [15:0] irq_vector,
	output logic      [1:0]  irq_in_service
);

	logic [7:0]        irq_enable_primary_r;
	logic [7:0]        irq_level_primary_r;
	logic [7:0]        irq_enable_level_secondary_r;
	logic [1:0]        in_service_r;
	logic [1:0]        in_service_nxt;
	logic [15:0]       vector_r;
	logic              sel_high_r;
	tlic_state_t       state_r;
	tlic_state_t       state_nxt;
	logic [NSRC-1:0]   src_req;
	logic [NSRC-1:0]   src_en;
	logic [NSRC-1:0]   src_high;
	logic [NSRC-1:0]   pend_high;
	logic [NSRC-1:0]   pend_low;
	logic              global_en;
	logic              take_high;
	logic              take_low;
	logic              take;
	logic [3:0]        idx_high;
	logic [3:0]        idx_low;
	logic [3:0]        idx_sel;
	logic [15:0]       vec_sel;
	logic              wr_ep;
	logic              wr_lp;
	logic              wr_sec;
	logic              bit_ep;
	logic              bit_lp;
	logic [7:0]        bit_mask;

	// first set bit in polling order
	function automatic logic [3:0] first_set(input logic [NSRC-1:0] v);
		logic [3:0] r;
		r = 4'hF;
		for (int i = NSRC - 1; i >= 0; i--) begin
			if (v[i]) begin
				r = 4'(i);
			end
		end
		return r;
	endfunction

	// vector for a source index
	function automatic logic [15:0] vec_of(input logic [3:0] i);
		case (i)
			4'(S_PSM): vec_of = VEC_PSM;
			4'(S_WDG): vec_of = VEC_WDG;
			4'(S_EX0): vec_of = VEC_EX0;
			4'(S_ADC): vec_of = VEC_ADC;
			4'(S_T0):  vec_of = VEC_T0;
			4'(S_EX1): vec_of = VEC_EX1;
			4'(S_T1):  vec_of = VEC_T1;
			4'(S_SSR): vec_of = VEC_SSR;
			4'(S_URT): vec_of = VEC_URT;
			4'(S_T2):  vec_of = VEC_T2;
			default:   vec_of = VEC_TIC;
		endcase
	endfunction

	// register write decode
	assign wr_ep    = sfr_wr && (sfr_addr == ADDR_ENABLE_PRI);
	assign wr_lp    = sfr_wr && (sfr_addr == ADDR_LEVEL_PRI);
	assign wr_sec   = sfr_wr && (sfr_addr == ADDR_ENLVL_SEC);
	assign bit_ep   = sfr_bit_wr && (sfr_addr == ADDR_ENABLE_PRI);
	assign bit_lp   = sfr_bit_wr && (sfr_addr == ADDR_LEVEL_PRI);
	assign bit_mask = 8'h01 << sfr_bit_sel;

	// register storage, secondary bit 3 held at zero whatever is written
	always_ff @(posedge mclk) begin
		if (rst) begin
			irq_enable_primary_r         <= RST_ENABLE_PRI;
			irq_level_primary_r          <= RST_LEVEL_PRI;
			irq_enable_level_secondary_r <= RST_ENLVL_SEC;
		end else begin
			if (wr_ep) begin
				irq_enable_primary_r <= sfr_wdata;
			end else if (bit_ep) begin
				irq_enable_primary_r <= sfr_bit_val ? (irq_enable_primary_r | bit_mask)
					: (irq_enable_primary_r & ~bit_mask);
			end
			if (wr_lp) begin
				irq_level_primary_r <= sfr_wdata & LEVEL_PRI_MASK;
			end else if (bit_lp) begin
				irq_level_primary_r <= (sfr_bit_val ? (irq_level_primary_r | bit_mask)
					: (irq_level_primary_r & ~bit_mask)) & LEVEL_PRI_MASK;
			end
			if (wr_sec) begin
				irq_enable_level_secondary_r <= (sfr_wdata & ENLVL_SEC_MASK)
					| (RST_ENLVL_SEC & ~ENLVL_SEC_MASK);
			end
		end
	end

	// read mux, unmapped addresses read zero
	assign sfr_rdata = (sfr_addr == ADDR_ENABLE_PRI) ? irq_enable_primary_r :
		(sfr_addr == ADDR_LEVEL_PRI) ? irq_level_primary_r :
		(sfr_addr == ADDR_ENLVL_SEC) ? irq_enable_level_secondary_r : 8'h00;

	// request gathering in polling order
	assign src_req[S_PSM] = supply_monitor_flag;
	assign src_req[S_WDG] = watchdog_timeout_flag && watchdog_irq_select
		&& (watchdog_period != 4'h0);
	assign src_req[S_EX0] = ext0_request_flag;
	assign src_req[S_ADC] = main_converter_ready || aux_converter_ready;
	assign src_req[S_T0]  = timer0_overflow_flag;
	assign src_req[S_EX1] = ext1_request_flag;
	assign src_req[S_T1]  = timer1_overflow_flag;
	assign src_req[S_SSR] = spi_done_flag || two_wire_done_flag;
	assign src_req[S_URT] = uart_rx_done || uart_tx_done;
	assign src_req[S_T2]  = timer2_overflow_flag || timer2_external_flag;
	assign src_req[S_TIC] = interval_counter_flag;

	// enables: global gates all but the watchdog
	assign global_en      = irq_enable_primary_r[GLOBAL_BIT];
	assign src_en[S_WDG]  = 1'b1;
	assign src_en[S_EX0]  = global_en && irq_enable_primary_r[0];
	assign src_en[S_T0]   = global_en && irq_enable_primary_r[1];
	assign src_en[S_EX1]  = global_en && irq_enable_primary_r[2];
	assign src_en[S_T1]   = global_en && irq_enable_primary_r[3];
	assign src_en[S_URT]  = global_en && irq_enable_primary_r[4];
	assign src_en[S_T2]   = global_en && irq_enable_primary_r[5];
	assign src_en[S_ADC]  = global_en && irq_enable_primary_r[6];
	assign src_en[S_SSR]  = global_en && irq_enable_level_secondary_r[0];
	assign src_en[S_PSM]  = global_en && irq_enable_level_secondary_r[1];
	assign src_en[S_TIC]  = global_en && irq_enable_level_secondary_r[2];

	// level selection per source
	assign src_high[S_WDG] = 1'b1;
	assign src_high[S_EX0] = irq_level_primary_r[0];
	assign src_high[S_T0]  = irq_level_primary_r[1];
	assign src_high[S_EX1] = irq_level_primary_r[2];
	assign src_high[S_T1]  = irq_level_primary_r[3];
	assign src_high[S_URT] = irq_level_primary_r[4];
	assign src_high[S_T2]  = irq_level_primary_r[5];
	assign src_high[S_ADC] = irq_level_primary_r[6];
	assign src_high[S_SSR] = irq_enable_level_secondary_r[SEC_LVL_LSB];
	assign src_high[S_PSM] = irq_enable_level_secondary_r[SEC_LVL_LSB + 1];
	assign src_high[S_TIC] = irq_enable_level_secondary_r[SEC_LVL_LSB + 2];

	// arbitration: high level wins, then polling order
	assign pend_high = src_req & src_en & src_high;
	assign pend_low  = src_req & src_en & ~src_high;
	assign take_high = (|pend_high) && !in_service_r[1];
	assign take_low  = (|pend_low) && (in_service_r == 2'b00);
	assign take      = (take_high || take_low) && (state_r == TLIC_IDLE) && core_irq_ready;
	assign idx_high  = first_set(pend_high);
	assign idx_low   = first_set(pend_low);
	assign idx_sel   = take_high ? idx_high : idx_low;
	assign vec_sel   = vec_of(idx_sel);

	// acceptance sequence: push then load
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			TLIC_IDLE: if (take) state_nxt = TLIC_PUSH;
			TLIC_PUSH: state_nxt = TLIC_LOAD;
			TLIC_LOAD: state_nxt = TLIC_IDLE;
			default:   state_nxt = TLIC_IDLE;
		endcase
	end

	// in-service levels, return releases the highest active one
	always_comb begin
		in_service_nxt = in_service_r;
		if (core_reti) begin
			if (in_service_r[1]) begin
				in_service_nxt[1] = 1'b0;
			end else begin
				in_service_nxt[0] = 1'b0;
			end
		end
		if (state_r == TLIC_LOAD) begin
			in_service_nxt[sel_high_r ? 1 : 0] = 1'b1;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			state_r      <= TLIC_IDLE;
			in_service_r <= 2'b00;
			vector_r     <= 16'h0000;
			sel_high_r   <= 1'b0;
		end else begin
			state_r      <= state_nxt;
			in_service_r <= in_service_nxt;
			if (take) begin
				vector_r   <= vec_sel;
				sel_high_r <= take_high;
			end
		end
	end

	// outputs to the core
	assign irq_push_pc    = (state_r == TLIC_PUSH);
	assign irq_load_pc    = (state_r == TLIC_LOAD);
	assign irq_vector     = vector_r;
	assign irq_in_service = in_service_r;

	// assertions
	property p_push_then_load;
		@(posedge mclk) disable iff (rst) irq_push_pc |=> irq_load_pc ##1 !irq_load_pc;
	endproperty
	a_push_then_load: assert property (p_push_then_load)
		else $error("load did not follow push");

	property p_take_push;
		@(posedge mclk) disable iff (rst) take |=> irq_push_pc;
	endproperty
	a_take_push: assert property (p_take_push)
		else $error("accepted request not pushed");

	property p_high_first;
		@(posedge mclk) disable iff (rst) (take && (|pend_high)) |=> sel_high_r;
	endproperty
	a_high_first: assert property (p_high_first)
		else $error("low level chosen over high");

	property p_no_same_level;
		@(posedge mclk) disable iff (rst) in_service_r[1] |-> !take;
	endproperty
	a_no_same_level: assert property (p_no_same_level)
		else $error("high routine preempted");

	property p_low_blocked;
		@(posedge mclk) disable iff (rst) (in_service_r[0] && take) |=> sel_high_r;
	endproperty
	a_low_blocked: assert property (p_low_blocked)
		else $error("low routine preempted by low");

	property p_global_off;
		@(posedge mclk) disable iff (rst)
			(take && !irq_enable_primary_r[GLOBAL_BIT]) |=> (vector_r == VEC_WDG);
	endproperty
	a_global_off: assert property (p_global_off)
		else $error("masked source taken with global off");

	property p_wdg_zero;
		@(posedge mclk) disable iff (rst) (watchdog_period == 4'h0) |-> !src_req[S_WDG];
	endproperty
	a_wdg_zero: assert property (p_wdg_zero)
		else $error("watchdog request with zero period");

	property p_psm_first;
		@(posedge mclk) disable iff (rst)
			(take && pend_high[S_PSM]) |=> (vector_r == VEC_PSM);
	endproperty
	a_psm_first: assert property (p_psm_first)
		else $error("supply monitor lost polling");

	property p_sec_bit3;
		@(posedge mclk) disable iff (rst) !irq_enable_level_secondary_r[3];
	endproperty
	a_sec_bit3: assert property (p_sec_bit3)
		else $error("secondary bit 3 set");

	property p_reti_release;
		@(posedge mclk) disable iff (rst)
			(core_reti && in_service_r == 2'b10 && state_r != TLIC_LOAD) |=> (in_service_r == 2'b00);
	endproperty
	a_reti_release: assert property (p_reti_release)
		else $error("return did not release level");

	c_nested: cover property (@(posedge mclk) disable iff (rst) in_service_r == 2'b11);
	c_wdg: cover property (@(posedge mclk) disable iff (rst) take && idx_sel == 4'(S_WDG));
	c_low: cover property (@(posedge mclk) disable iff (rst) take && !take_high);
endmodule

// ===== design/tlic_pkg.sv
// Summary of operation
// - eleven sources, each except the watchdog assignable to high or low priority level
// - primary enable bit 7 is global enable for all maskable sources
// - primary enable bits 6..0 enable converter, timer2, uart, timer1, ext1, timer0, ext0
// - primary level bits 6..0 choose high level for converter, timer2, uart, timer1, ext1, timer0, ext0; bit 7 reserved
// - secondary bits 2..0 enable interval counter, supply monitor, sync serial
// - secondary bits 6..4 choose level for interval counter, supply monitor, sync serial
// - pending enabled high request preempts a running low level routine
// - same-cycle requests of both levels: high level serviced first
// - routine never preempted by request of its own level
// - same level ties resolved by fixed polling order, supply monitor first
// - on acceptance push program counter, then load selected vector
// - classic vectors 0003H, 000BH, 0013H, 001BH, 0023H, 002BH
// - added vectors 0033H, 003BH, 0043H, 0053H, 005BH
// - watchdog timeout raises interrupt when interrupt-select bit is one
// - watchdog interrupt is always high level
// - global enable clear never masks the watchdog interrupt
// - watchdog interrupt only when configured timeout period exceeds zero
// - primary enable and level reset to zero, bit addressable
// - secondary register resets to A0H, byte access only
// - registers at A8H, B8H and A9H in special function space
package tlic_pkg;
	localparam logic [7:0]  ADDR_ENABLE_PRI = 8'hA8;
	localparam logic [7:0]  ADDR_LEVEL_PRI  = 8'hB8;
	localparam logic [7:0]  ADDR_ENLVL_SEC  = 8'hA9;
	localparam logic [7:0]  RST_ENABLE_PRI  = 8'h00;
	localparam logic [7:0]  RST_LEVEL_PRI   = 8'h00;
	localparam logic [7:0]  RST_ENLVL_SEC   = 8'hA0;
	localparam int          GLOBAL_BIT      = 7;
	localparam int          SEC_LVL_LSB     = 4;
	localparam logic [7:0]  LEVEL_PRI_MASK  = 8'h7F;
	localparam logic [7:0]  ENLVL_SEC_MASK  = 8'h77;
	localparam int          NSRC            = 11;
	// source index equals polling position, 0 is first
	localparam int          S_PSM = 0;
	localparam int          S_WDG = 1;
	localparam int          S_EX0 = 2;
	localparam int          S_ADC = 3;
	localparam int          S_T0  = 4;
	localparam int          S_EX1 = 5;
	localparam int          S_T1  = 6;
	localparam int          S_SSR = 7;
	localparam int          S_URT = 8;
	localparam int          S_T2  = 9;
	localparam int          S_TIC = 10;
	localparam logic [15:0] VEC_EX0 = 16'h0003;
	localparam logic [15:0] VEC_T0  = 16'h000B;
	localparam logic [15:0] VEC_EX1 = 16'h0013;
	localparam logic [15:0] VEC_T1  = 16'h001B;
	localparam logic [15:0] VEC_URT = 16'h0023;
	localparam logic [15:0] VEC_T2  = 16'h002B;
	localparam logic [15:0] VEC_ADC = 16'h0033;
	localparam logic [15:0] VEC_SSR = 16'h003B;
	localparam logic [15:0] VEC_PSM = 16'h0043;
	localparam logic [15:0] VEC_TIC = 16'h0053;
	localparam logic [15:0] VEC_WDG = 16'h005B;
	typedef enum logic [1:0] {TLIC_IDLE, TLIC_PUSH, TLIC_LOAD} tlic_state_t;
endpackage

// ===== bench/tlic_core_model.sv
// core side of the handshake: accepts when not stalled, returns on command
module tlic_core_model (
	// clock and reset
	input  wire logic mclk,
	input  wire logic rst,
	// controller outputs seen by the core
	input  wire logic irq_push_pc,
	input  wire logic irq_load_pc,
	// bench commands
	input  wire logic stall,
	input  wire logic svc_done,
	// answers to the controller
	output logic      core_irq_ready,
	output logic      core_reti,
	output logic      seq_err
);
	timeunit 1ns;
	timeprecision 100ps;

	logic push_d_r;

	// a stalled core refuses new entries, the slow answer
	assign core_irq_ready = !stall;

	// return pulse follows the bench command, and load must follow push
	always_ff @(posedge mclk) begin
		if (rst) begin
			push_d_r  <= 1'b0;
			core_reti <= 1'b0;
			seq_err   <= 1'b0;
		end else begin
			push_d_r  <= irq_push_pc;
			core_reti <= svc_done;
			if (irq_load_pc && !push_d_r) begin
				seq_err <= 1'b1;
			end
		end
	end
endmodule

// ===== bench/tb_two_level_irq_controller.sv
module tb_two_level_irq_controller;
	import tlic_pkg::*;
	timeunit 1ns;
	timeprecision 100ps;

	logic        mclk        = 1'b0;
	logic        rst         = 1'b1;
	logic [7:0]  sfr_addr    = 8'h00;
	logic [7:0]  sfr_wdata   = 8'h00;
	logic        sfr_wr      = 1'b0;
	logic        sfr_bit_wr  = 1'b0;
	logic [2:0]  sfr_bit_sel = 3'h0;
	logic        sfr_bit_val = 1'b0;
	logic [10:0] src         = '0;
	logic        alt         = 1'b0;
	logic        wsel        = 1'b0;
	logic [3:0]  wper        = 4'h3;
	logic        stall       = 1'b0;
	logic        svc_done    = 1'b0;
	logic        core_irq_ready;
	logic        core_reti;
	logic        seq_err;
	logic        irq_push_pc;
	logic        irq_load_pc;
	logic [7:0]  sfr_rdata;
	logic [15:0] irq_vector;
	logic [1:0]  irq_in_service;
	int          err_count   = 0;
	int          num_checks  = 0;
	logic [15:0] vtab [11]   = '{VEC_PSM, VEC_WDG, VEC_EX0, VEC_ADC, VEC_T0, VEC_EX1,
		VEC_T1, VEC_SSR, VEC_URT, VEC_T2, VEC_TIC};

	always #2.5 mclk = ~mclk;

	// paired sources are driven one input or the other by alt
	tlic_ctrl dut (.mclk(mclk), .rst(rst), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
		.sfr_wr(sfr_wr), .sfr_bit_wr(sfr_bit_wr), .sfr_bit_sel(sfr_bit_sel),
		.sfr_bit_val(sfr_bit_val), .sfr_rdata(sfr_rdata),
		.ext0_request_flag(src[S_EX0]), .timer0_overflow_flag(src[S_T0]),
		.ext1_request_flag(src[S_EX1]), .timer1_overflow_flag(src[S_T1]),
		.uart_rx_done(src[S_URT] & ~alt), .uart_tx_done(src[S_URT] & alt),
		.timer2_overflow_flag(src[S_T2] & ~alt), .timer2_external_flag(src[S_T2] & alt),
		.main_converter_ready(src[S_ADC] & ~alt), .aux_converter_ready(src[S_ADC] & alt),
		.spi_done_flag(src[S_SSR] & ~alt), .two_wire_done_flag(src[S_SSR] & alt),
		.supply_monitor_flag(src[S_PSM]), .interval_counter_flag(src[S_TIC]),
		.watchdog_timeout_flag(src[S_WDG]), .watchdog_irq_select(wsel),
		.watchdog_period(wper), .core_irq_ready(core_irq_ready), .core_reti(core_reti),
		.irq_push_pc(irq_push_pc), .irq_load_pc(irq_load_pc), .irq_vector(irq_vector),
		.irq_in_service(irq_in_service));

	tlic_core_model core (.mclk(mclk), .rst(rst), .irq_push_pc(irq_push_pc),
		.irq_load_pc(irq_load_pc), .stall(stall), .svc_done(svc_done),
		.core_irq_ready(core_irq_ready), .core_reti(core_reti), .seq_err(seq_err));

	task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
		num_checks++;
		if (g !== e) begin
			$display("BAD %s exp %h got %h", n, e, g);
			err_count++;
		end
	endtask

	task automatic chk16(input string n, input logic [15:0] e, input logic [15:0] g);
		num_checks++;
		if (g !== e) begin
			$display("BAD %s exp %h got %h", n, e, g);
			err_count++;
		end
	endtask

	task automatic chk1(input string n, input logic e, input logic g);
		num_checks++;
		if (g !== e) begin
			$display("BAD %s exp %b got %b", n, e, g);
			err_count++;
		end
	endtask

	task automatic end_of_test();
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// byte write, strobe high for one edge, one idle edge after
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		sfr_addr = a;
		sfr_wdata = d;
		sfr_wr = 1'b1;
		@(posedge mclk);
		#1 sfr_wr = 1'b0;
		@(posedge mclk);
		#1;
	endtask

	task automatic bw(input logic [7:0] a, input logic [2:0] b, input logic v);
		sfr_addr = a;
		sfr_bit_sel = b;
		sfr_bit_val = v;
		sfr_bit_wr = 1'b1;
		@(posedge mclk);
		#1 sfr_bit_wr = 1'b0;
		@(posedge mclk);
		#1;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		sfr_addr = a;
		#1 chk8("rdata", e, sfr_rdata);
	endtask

	// waits a bounded time for entry, then checks push, vector and load
	task automatic take(input logic [15:0] ev);
		int k;
		k = 0;
		while (irq_push_pc !== 1'b1 && k < 40) begin
			@(posedge mclk);
			#1 k++;
		end
		chk1("push", 1'b1, irq_push_pc);
		chk16("vector", ev, irq_vector);
		@(posedge mclk);
		#1 chk1("load", 1'b1, irq_load_pc);
		@(posedge mclk);
		#1;
	endtask

	task automatic idle(input int n);
		repeat (n) begin
			@(posedge mclk);
			#1 chk1("no_push", 1'b0, irq_push_pc);
		end
	endtask

	task automatic reti_done();
		svc_done = 1'b1;
		@(posedge mclk);
		#1 svc_done = 1'b0;
		@(posedge mclk);
		#1;
	endtask

	task automatic insvc(input logic [1:0] e);
		chk8("in_service", {6'h00, e}, {6'h00, irq_in_service});
	endtask

	// cuts a hang short
	initial begin
		repeat (20000) @(posedge mclk);
		err_count++;
		end_of_test();
	end

	initial begin
		repeat (8) @(posedge mclk);
		#1 rst = 1'b0;
		rd(ADDR_ENABLE_PRI, 8'h00);
		rd(ADDR_LEVEL_PRI, 8'h00);
		rd(ADDR_ENLVL_SEC, 8'hA0);
		rd(8'h55, 8'h00);
		wr(ADDR_ENABLE_PRI, 8'h81);
		rd(ADDR_ENABLE_PRI, 8'h81);
		wr(ADDR_LEVEL_PRI, 8'hFF);
		rd(ADDR_LEVEL_PRI, 8'h7F);
		wr(ADDR_ENLVL_SEC, 8'h77);
		rd(ADDR_ENLVL_SEC, 8'hF7);
		bw(ADDR_ENABLE_PRI, 3'h0, 1'b0);
		rd(ADDR_ENABLE_PRI, 8'h80);
		bw(ADDR_LEVEL_PRI, 3'h6, 1'b0);
		rd(ADDR_LEVEL_PRI, 8'h3F);
		bw(ADDR_ENLVL_SEC, 3'h0, 1'b0);
		rd(ADDR_ENLVL_SEC, 8'hF7);
		// each source alone, second input of each pair
		wr(ADDR_ENABLE_PRI, 8'hFF);
		wr(ADDR_LEVEL_PRI, 8'h00);
		wr(ADDR_ENLVL_SEC, 8'h07);
		wsel = 1'b1;
		alt = 1'b1;
		for (int i = 0; i < NSRC; i++) begin
			src = 11'(1) << i;
			take(vtab[i]);
			src = '0;
			reti_done();
		end
		// global enable off, then a stalled core
		wr(ADDR_ENABLE_PRI, 8'h7F);
		src[S_EX0] = 1'b1;
		idle(6);
		stall = 1'b1;
		wr(ADDR_ENABLE_PRI, 8'hFF);
		idle(6);
		stall = 1'b0;
		take(VEC_EX0);
		src = '0;
		reti_done();
		// polling order, first inputs of each pair, watchdog not selected
		wsel = 1'b0;
		alt = 1'b0;
		src = '1;
		for (int k = 0; k < NSRC; k++) begin
			if (k != S_WDG) begin
				take(vtab[k]);
				src[k] = 1'b0;
				reti_done();
			end
		end
		idle(6);
		wr(ADDR_ENABLE_PRI, 8'h00);
		wsel = 1'b1;
		wper = 4'h0;
		idle(6);
		wper = 4'h3;
		take(VEC_WDG);
		src = '0;
		reti_done();
		// both levels in the same cycle
		wr(ADDR_ENABLE_PRI, 8'hFF);
		wr(ADDR_ENLVL_SEC, 8'h47);
		src = (11'(1) << S_EX0) | (11'(1) << S_TIC);
		take(VEC_TIC);
		src[S_TIC] = 1'b0;
		reti_done();
		take(VEC_EX0);
		src = '0;
		reti_done();
		wr(ADDR_ENLVL_SEC, 8'h07);
		src = (11'(1) << S_PSM) | (11'(1) << S_WDG);
		take(VEC_WDG);
		src[S_WDG] = 1'b0;
		reti_done();
		take(VEC_PSM);
		src = '0;
		reti_done();
		// supply monitor raised to high level ties with the watchdog
		wr(ADDR_ENLVL_SEC, 8'h27);
		src = (11'(1) << S_PSM) | (11'(1) << S_WDG);
		take(VEC_PSM);
		src[S_PSM] = 1'b0;
		idle(4);
		reti_done();
		take(VEC_WDG);
		src = '0;
		reti_done();
		// high preempts low, a low request never preempts a low routine
		wr(ADDR_ENABLE_PRI, 8'h8F);
		wr(ADDR_LEVEL_PRI, 8'h02);
		src[S_EX0] = 1'b1;
		take(VEC_EX0);
		src = '0;
		insvc(2'b01);
		src = (11'(1) << S_T0) | (11'(1) << S_EX1);
		take(VEC_T0);
		src[S_T0] = 1'b0;
		insvc(2'b11);
		idle(6);
		reti_done();
		insvc(2'b01);
		idle(6);
		reti_done();
		take(VEC_EX1);
		src = '0;
		reti_done();
		insvc(2'b00);
		chk1("order", 1'b0, seq_err);
		end_of_test();
	end
endmodule
